/* File: rtl/asm_edge_sync.sv */
// Two-flop synchroniser with edge detection for a pin input
module asm_edge_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // Pin and results
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta;
  logic held;

  // ----------------------------------------------------------------
  // Synchroniser; only the second and third stages are ever inspected
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      meta  <= 1'b1;
      level <= 1'b1;
      held  <= 1'b1;
    end else begin
      meta  <= pin;
      level <= meta;
      held  <= level;
    end
  end

  // Edges from the settled level
  assign rise = level & ~held;
  assign fall = ~level & held;

endmodule

/* File: rtl/asm_pkg.sv */
// Package of constants for the converter status and mode register block
package asm_pkg;

  // ----------------------------------------------------------------
  // Register selection and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  SEL_CONDITION   = 3'h0;
  localparam logic [2:0]  SEL_SETUP       = 3'h1;
  localparam logic [7:0]  CONDITION_RESET = 8'h88;
  localparam logic [15:0] SETUP_RESET     = 16'h000A;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CMD_WRITE_ENABLE_BIT = 7;
  localparam int CMD_READ_BIT         = 6;
  localparam int CMD_SEL_HI           = 5;
  localparam int CMD_SEL_LO           = 3;
  localparam int MODE_HI              = 15;
  localparam int MODE_LO              = 13;
  localparam int SETUP_RESERVED_MASK_LO = 0;

  // Operating mode codes
  localparam logic [2:0] MODE_POWER_DOWN = 3'h3;
  localparam logic [2:0] MODE_IDLE       = 3'h2;

  // ----------------------------------------------------------------
  // Timing: status raised this long before a new result lands
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ          = 250;
  localparam int PENDING_LEAD_NS    = 100;
  localparam int PENDING_LEAD_CYCLES = (PENDING_LEAD_NS * CLOCK_MHZ) / 1000;

  // Serial transfer phases
  typedef enum logic [1:0] {
    ASM_CMD   = 2'b00,
    ASM_DATA  = 2'b01,
    ASM_WRITE = 2'b11
  } asm_phase_e;

endpackage

/* File: rtl/asm_status_mode.sv */
// Status and mode registers behind a four-wire serial port
module asm_status_mode #(
  parameter int LEAD_CYCLES = asm_pkg::PENDING_LEAD_CYCLES
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // Serial port pins
  input  wire logic        serial_clock,
  input  wire logic        data_in,
  input  wire logic        chip_select_n,
  output logic             data_out_ready_n,
  // Converter core events
  input  wire logic        result_load,
  input  wire logic        result_clamped,
  input  wire logic        result_soon,
  input  wire logic        data_read_done,
  input  wire logic [2:0]  active_channel_bits,
  input  wire logic        reference_low,
  input  wire logic        reference_detect_enable,
  // Converter control outputs
  output logic [15:0]      operating_setup,
  output logic             filter_restart
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic sclk_level;
  logic sclk_rise;
  logic sclk_fall;
  logic din_level;
  logic cs_level_n;
  logic din_meta;
  logic cs_meta_n;

  asm_edge_sync u_sclk (
    .mclk  (mclk),
    .reset (reset),
    .pin   (serial_clock),
    .level (sclk_level),
    .rise  (sclk_rise),
    .fall  (sclk_fall)
  );

  // Plain two-stage sync for data and select
  always_ff @(posedge mclk) begin
    if (reset) begin
      din_meta   <= 1'b0;
      din_level  <= 1'b0;
      cs_meta_n  <= 1'b1;
      cs_level_n <= 1'b1;
    end else begin
      din_meta   <= data_in;
      din_level  <= din_meta;
      cs_meta_n  <= chip_select_n;
      cs_level_n <= cs_meta_n;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  logic       pending_n;
  logic       clamp_fault;
  logic       reference_missing_flag;
  logic       conversion_write;
  logic       powering_down;
  logic [7:0] converter_condition;
  logic [$clog2(LEAD_CYCLES + 1)-1:0] lead_count;

  // Missing reference only judged while detection is enabled
  always_ff @(posedge mclk) begin
    if (reset) begin
      reference_missing_flag <= 1'b0;
    end else begin
      reference_missing_flag <= reference_detect_enable & reference_low;
    end
  end

  // Lead counter: result_soon starts a delay before pending rises
  always_ff @(posedge mclk) begin
    if (reset) begin
      lead_count <= '0;
    end else if (result_soon) begin
      lead_count <= ($clog2(LEAD_CYCLES + 1))'(LEAD_CYCLES);
    end else if (lead_count != '0) begin
      lead_count <= lead_count - 1'b1;
    end
  end

  // Pending flag; a fresh result wins over any setting event
  always_ff @(posedge mclk) begin
    if (reset) begin
      pending_n <= asm_pkg::CONDITION_RESET[7];
    end else if (result_load) begin
      pending_n <= 1'b0;
    end else if (data_read_done || lead_count == 1 || conversion_write || powering_down) begin
      pending_n <= 1'b1;
    end
  end

  // Clamp fault written with the pending flag; a fresh result wins over the write clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      clamp_fault <= asm_pkg::CONDITION_RESET[6];
    end else if (result_load) begin
      clamp_fault <= result_clamped | reference_missing_flag;
    end else if (conversion_write) begin
      clamp_fault <= 1'b0;
    end
  end

  // Status image; reading it touches nothing
  assign converter_condition = {pending_n, clamp_fault, reference_missing_flag,
                                1'b0, 1'b1, active_channel_bits};

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  asm_pkg::asm_phase_e phase;
  logic [15:0] shift_in;
  logic [15:0] shift_out;
  logic [4:0]  bit_count;
  logic [4:0]  data_bits;
  logic        reading;
  logic [2:0]  selected;
  logic        driving;

  // Command then data; each transfer bit taken on serial clock rise
  always_ff @(posedge mclk) begin
    if (reset) begin
      phase     <= asm_pkg::ASM_CMD;
      shift_in  <= '0;
      bit_count <= '0;
      data_bits <= '0;
      reading   <= 1'b0;
      selected  <= '0;
      driving   <= 1'b0;
    end else if (cs_level_n) begin
      phase     <= asm_pkg::ASM_CMD;
      bit_count <= '0;
      driving   <= 1'b0;
    end else if (sclk_rise) begin
      shift_in <= {shift_in[14:0], din_level};
      case (phase)
        asm_pkg::ASM_CMD: begin
          // A leading one holds the engine at the first bit
          if (bit_count == '0 && din_level) begin
            bit_count <= '0;
          end else if (bit_count == 5'd7) begin
            bit_count <= '0;
            reading   <= shift_in[5];
            selected  <= shift_in[4:2];
            data_bits <= (shift_in[4:2] == asm_pkg::SEL_SETUP) ? 5'd16 : 5'd8;
            driving   <= shift_in[5];
            phase     <= asm_pkg::ASM_DATA;
          end else begin
            bit_count <= bit_count + 5'd1;
          end
        end
        asm_pkg::ASM_DATA: begin
          if (bit_count == data_bits - 5'd1) begin
            bit_count <= '0;
            driving   <= 1'b0;
            phase     <= reading ? asm_pkg::ASM_CMD : asm_pkg::ASM_WRITE;
          end else begin
            bit_count <= bit_count + 5'd1;
          end
        end
        default: begin
          phase <= asm_pkg::ASM_CMD;
        end
      endcase
    end else if (phase == asm_pkg::ASM_WRITE) begin
      phase <= asm_pkg::ASM_CMD;
    end
  end

  // Read data loaded on command end, shifted on falling clock
  always_ff @(posedge mclk) begin
    if (reset) begin
      shift_out <= '0;
    end else if (sclk_rise && phase == asm_pkg::ASM_CMD && bit_count == 5'd7) begin
      if (shift_in[4:2] == asm_pkg::SEL_SETUP) begin
        shift_out <= operating_setup;
      end else begin
        shift_out <= {converter_condition, 8'h00};
      end
    end else if (sclk_fall && driving && bit_count != '0) begin
      // First data fall only presents the MSB; shifting there would lose it
      shift_out <= {shift_out[14:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Mode register and its side effects
  // ----------------------------------------------------------------
  logic write_done;
  assign write_done = (phase == asm_pkg::ASM_WRITE) && !reading
                      && selected == asm_pkg::SEL_SETUP;
  assign conversion_write = write_done;
  assign powering_down = operating_setup[asm_pkg::MODE_HI:asm_pkg::MODE_LO]
                         == asm_pkg::MODE_POWER_DOWN;

  // Stored MSB first as shifted in; host keeps reserved bits zero
  always_ff @(posedge mclk) begin
    if (reset) begin
      operating_setup <= asm_pkg::SETUP_RESET;
      filter_restart  <= 1'b0;
    end else begin
      filter_restart <= write_done;
      if (write_done) begin
        operating_setup <= shift_in;
      end
    end
  end

  // Shared pin: data while reading, otherwise the ready level
  always_ff @(posedge mclk) begin
    if (reset) begin
      data_out_ready_n <= 1'b1;
    end else if (driving) begin
      data_out_ready_n <= shift_out[15];
    end else begin
      data_out_ready_n <= pending_n;
    end
  end

endmodule

/* File: verification/asm_host_model.sv */
// Host model driving the four-wire serial port from the far side
module asm_host_model (
  // Clock
  input  wire logic mclk,
  // Serial port
  output logic      serial_clock,
  output logic      data_in,
  output logic      chip_select_n,
  input  wire logic data_out_ready_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // Serial clock parked high between frames
  initial begin
    serial_clock  = 1'b1;
    data_in       = 1'b1;
    chip_select_n = 1'b1;
  end

  // Command byte then nbits of data, MSB first; abort_at drops select early
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wdata, input int nbits,
                      input int abort_at, output logic [15:0] rdata);
    logic [23:0] bits;
    bits  = {cmd, wdata};
    rdata = 16'h0000;
    @(posedge mclk);
    chip_select_n <= 1'b0;
    repeat (8) @(posedge mclk);
    for (int i = 0; i < 8 + nbits && i != abort_at; i++) begin
      serial_clock <= 1'b0;
      data_in      <= bits[23-i];
      repeat (7) @(posedge mclk);
      @(negedge mclk);
      if (i >= 8) rdata = {rdata[14:0], data_out_ready_n};
      @(posedge mclk);
      serial_clock <= 1'b1;
      repeat (8) @(posedge mclk);
    end
    // Released line shows the inverse so a stale bit cannot pass
    chip_select_n <= 1'b1;
    data_in       <= ~data_in;
    repeat (8) @(posedge mclk);
  endtask
endmodule

/* File: verification/asm_status_mode_props.sv */
// Port checks for the converter status and mode register block
module asm_status_mode_props #(
  parameter int LEAD_CYCLES = 2
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset,
  // Serial port and core events
  input wire logic        serial_clock,
  input wire logic        data_in,
  input wire logic        chip_select_n,
  input wire logic        data_out_ready_n,
  input wire logic        result_load,
  input wire logic        result_clamped,
  input wire logic        result_soon,
  input wire logic        data_read_done,
  input wire logic [2:0]  active_channel_bits,
  input wire logic        reference_low,
  input wire logic        reference_detect_enable,
  // Mode outputs
  input wire logic [15:0] operating_setup,
  input wire logic        filter_restart
);
  localparam int SOON_LAT = LEAD_CYCLES + 3;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Power-down holds the pin at not-ready, so guards exclude it
  wire pd = operating_setup[15:13] == 3'h3;

  a_reset_values: assert property (
    $fell(reset) |-> operating_setup == 16'h000A && data_out_ready_n) else $error("bad reset");
  a_restart_single: assert property (
    filter_restart |=> !filter_restart) else $error("restart too long");
  a_write_restart: assert property (
    $changed(operating_setup) |-> ##[0:2] filter_restart) else $error("no restart");
  a_setup_in_frame: assert property (
    $changed(operating_setup) |-> !$past(chip_select_n, 4)) else $error("setup moved");
  a_load_ready: assert property (
    result_load && chip_select_n && !pd ##1 (chip_select_n && !data_read_done)[*2]
    |-> !data_out_ready_n) else $error("load kept not-ready");
  a_done_ready: assert property (
    data_read_done && chip_select_n ##1 (chip_select_n && !result_load)[*2]
    |-> data_out_ready_n) else $error("read kept ready");
  a_soon_ready: assert property (
    result_soon && chip_select_n && !result_load |-> ##[1:SOON_LAT] data_out_ready_n)
    else $error("no lead warning");
  a_pd_ready: assert property (
    pd && !result_load && chip_select_n ##1 chip_select_n |=> data_out_ready_n)
    else $error("power-down ready");

  c_clamped: cover property (result_load && result_clamped);
  c_restart: cover property (filter_restart);
  c_pd: cover property (pd && chip_select_n);
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the converter status and mode register block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int LEAD = 2;
  logic        mclk, reset, serial_clock, data_in, chip_select_n, data_out_ready_n;
  logic        result_load, result_clamped, result_soon, data_read_done;
  logic [2:0]  ch;
  logic        ref_low, ref_en, filter_restart, pend_n, err;
  logic [15:0] setup, rd, val;
  logic [31:0] seed = 32'h18;
  int          err_total, n_checks, restarts;

  asm_status_mode #(.LEAD_CYCLES(LEAD)) i_dut (.mclk(mclk), .reset(reset),
    .serial_clock(serial_clock), .data_in(data_in), .chip_select_n(chip_select_n),
    .data_out_ready_n(data_out_ready_n), .result_load(result_load),
    .result_clamped(result_clamped), .result_soon(result_soon),
    .data_read_done(data_read_done), .active_channel_bits(ch), .reference_low(ref_low),
    .reference_detect_enable(ref_en), .operating_setup(setup),
    .filter_restart(filter_restart));
  asm_host_model i_host (.mclk(mclk), .serial_clock(serial_clock), .data_in(data_in),
    .chip_select_n(chip_select_n), .data_out_ready_n(data_out_ready_n));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(negedge mclk) if (filter_restart === 1'b1) restarts++;

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected status from tracked flags and live core levels
  function logic [7:0] exp_status();
    return {pend_n, err, ref_low & ref_en, 1'b0, 1'b1, ch};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One core event: 0 result due, 1 result stored, 2 data read out
  task automatic ev(input int k);
    @(posedge mclk);
    {result_soon, result_load, data_read_done} <= {k == 0, k == 1, k == 2};
    @(posedge mclk);
    {result_soon, result_load, data_read_done} <= 3'b000;
    repeat (LEAD + 4) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic rd_status(input logic [7:0] cmd);
    i_host.xfer(cmd, 16'h0000, 8, 99, rd);
    chk({8'h00, rd[7:0]}, {8'h00, exp_status()}, "status");
  endtask

  task automatic summarize();
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    summarize();
  end

  initial begin
    reset = 1'b1;
    {result_load, result_clamped, result_soon, data_read_done} = 4'h0;
    {ch, ref_low, ref_en, pend_n, err} = 7'h02;
    {err_total, n_checks, restarts} = 0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    rd_status(8'h40);
    i_host.xfer(8'h48, 16'h0000, 16, 99, rd);
    chk(rd, 16'h000A, "mode reset");
    // Conversions with random channel, reference and clamp
    for (int i = 0; i < 6; i++) begin
      val = rnd();
      @(posedge mclk);
      {ch, ref_low, ref_en, result_clamped} <= val[5:0];
      ev(1);
      pend_n = 1'b0;
      err    = val[0] | (val[2] & val[1]);
      chk({15'h0, data_out_ready_n}, 16'h0000, "ready pin");
      rd_status(i[0] ? 8'h50 : 8'h40);
      rd_status(8'h40);
      ev(i[0] ? 0 : 2);
      pend_n = 1'b1;
      rd_status(8'h40);
    end
    // Mode writes, the last one into power-down
    @(posedge mclk);
    ref_low <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      val = rnd() & 32'hF2FF;
      if (i == 3) val[15:13] = 3'h3;
      i_host.xfer(8'h08, val, 16, 99, rd);
      {pend_n, err} = 2'b10;
      chk(setup, val, "mode out");
      i_host.xfer(8'h48, 16'h0000, 16, 99, rd);
      chk(rd, val, "mode read");
      rd_status(8'h40);
    end
    chk(restarts[15:0], 16'h0004, "restarts");
    @(posedge mclk);
    result_clamped <= 1'b0;
    ev(1);
    rd_status(8'h40);
    i_host.xfer(8'h08, 16'h0000, 16, 12, rd);
    i_host.xfer(8'h48, 16'h0000, 16, 99, rd);
    chk(rd, val, "aborted write");
    summarize();
  end
endmodule

bind asm_status_mode asm_status_mode_props #(.LEAD_CYCLES(LEAD_CYCLES)) i_props (
  .mclk(mclk), .reset(reset), .serial_clock(serial_clock), .data_in(data_in),
  .chip_select_n(chip_select_n), .data_out_ready_n(data_out_ready_n),
  .result_load(result_load), .result_clamped(result_clamped), .result_soon(result_soon),
  .data_read_done(data_read_done), .active_channel_bits(active_channel_bits),
  .reference_low(reference_low), .reference_detect_enable(reference_detect_enable),
  .operating_setup(operating_setup), .filter_restart(filter_restart));
